// file: tb/scp_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// Host side of the link: makes sclk, csN and its share of the pin
module scp_host_model (
  input wire logic mclk,
  input wire logic sdioLine,
  output logic sclk,
  output logic csN,
  output logic hostOut,
  output logic hostOe
);
  localparam int HALF = 8; // Half link period, 160 ns in all

  // Idle link: clock still low, select high
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    hostOut = 1'b0;
    hostOe = 1'b0;
  end

  // Open a frame and wait a half period; first rise comes a full period after select falls
  task automatic selectOn();
    @(posedge mclk) csN <= 1'b0;
    repeat (HALF) @(posedge mclk);
  endtask : selectOn

  // Close or stall a frame and let go of the pin
  task automatic selectOff();
    @(posedge mclk) begin
      csN <= 1'b1;
      hostOe <= 1'b0;
    end
    repeat (HALF) @(posedge mclk);
  endtask : selectOff

  // One bit: data set while low, pin sampled just before the rise
  task automatic sendBit(input logic b, input logic drive,
      output logic got);
    @(posedge mclk) begin
      hostOe <= drive;
      hostOut <= b;
    end
    repeat (HALF - 1) @(posedge mclk);
    got = sdioLine;
    sclk <= 1'b1;
    repeat (HALF) @(posedge mclk);
    sclk <= 1'b0;
  endtask : sendBit

  // Eight bits in either order; got gathers what the pin showed
  task automatic sendByte(input logic [7:0] v, input logic lsb,
      input logic drive, output logic [7:0] got);
    logic b;
    for (int i = 0; i < 8; i++) begin
      sendBit(v[lsb ? i : 7 - i], drive, b);
      got[lsb ? i : 7 - i] = b;
    end
  endtask : sendByte
endmodule : scp_host_model
`default_nettype wire

// file: tb/test_serial_config_port_front.sv
`timescale 1ns/1ns
`default_nettype none

module test_serial_config_port_front;
  import scp_pkg::*;
  logic mclk, rst_n, lsbFirst, noise, sdioOut, sdioOe;
  logic sclk, csN, hostOut, hostOe, sdioLine;
  logic [7:0] rdGot, rdData;
  logic [7:0] mem [256]; // Register file stand-in
  reg_req_t regReq;
  logic [20:0] expWr[$]; // Expected {addr, data} writes
  logic [12:0] expAddr[$]; // Expected read addresses
  logic [7:0] expRd[$]; // Expected read bytes
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  event rdSeen;

  // Pin level; undriven line wanders
  assign sdioLine = sdioOe ? sdioOut : (hostOe ? hostOut : noise);
  assign rdData = mem[regReq.addr[7:0]];

  serial_config_port_front DUT (.mclk(mclk), .rst_n(rst_n),
    .sclk(sclk), .csN(csN), .sdioIn(sdioLine), .sdioOut(sdioOut),
    .sdioOe(sdioOe), .lsbFirst(lsbFirst), .regReq(regReq),
    .regRdData(rdData));
  scp_host_model host (.mclk(mclk), .sdioLine(sdioLine), .sclk(sclk),
    .csN(csN), .hostOut(hostOut), .hostOe(hostOe));

  // Clock and floating-line pattern
  initial begin
    mclk = 1'b0;
    noise = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) noise <= ~noise;

  // Compare a register request
  task automatic checkReq(input string what, input logic [20:0] e, g);
    cmp_count++;
    if (e !== g) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : checkReq

  // Compare a pin level or a byte seen at the pin
  task automatic checkPin(input string what, input logic [7:0] e, g);
    cmp_count++;
    if (e !== g) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : checkPin

  // Watch the register side and the read bytes
  always @(posedge mclk) begin
    if (regReq.write === 1'b1) begin
      checkReq("write", expWr.size() ? expWr.pop_front() : 'x,
        {regReq.addr, regReq.data});
      mem[regReq.addr[7:0]] <= regReq.data;
    end
    if (regReq.read === 1'b1) begin
      checkReq("read addr", expAddr.size() ?
        {expAddr.pop_front(), 8'h00} : 'x, {regReq.addr, 8'h00});
    end
  end
  always @(rdSeen) begin
    checkPin("read byte", expRd.size() ? expRd.pop_front() : 'x,
      rdGot);
  end

  // Whole cycle: instruction, nb bytes, optional stall after byte stall
  task automatic xfer(input logic rw, input logic [1:0] len,
      input logic [7:0] a, input logic lsb, input int nb, input int stall);
    logic [15:0] w;
    logic [7:0] d, g, pa;
    logic live;
    w = {rw, len, 5'h00, a};
    // Read fetches start right after the instruction: note them first
    live = 1'b1;
    pa = a;
    for (int i = 0; i < nb; i++) begin
      if (live && rw) begin
        expAddr.push_back({5'h00, pa});
        expRd.push_back(mem[pa]);
      end
      live = live && (len == LEN_STREAM ? pa != STREAM_END_ADDR
        : i < len);
      pa = lsb ? pa + 8'h01 : pa - 8'h01;
    end
    live = 1'b1;
    @(posedge mclk) lsbFirst <= lsb;
    host.selectOn();
    host.sendByte(lsb ? w[7:0] : w[15:8], lsb, 1'b1, g);
    host.sendByte(lsb ? w[15:8] : w[7:0], lsb, 1'b1, g);
    checkPin("oe after instr", {7'h00, rw}, {7'h00, sdioOe});
    for (int i = 0; i < nb; i++) begin
      d = 8'($urandom);
      if (live && !rw) expWr.push_back({5'h00, a, d});
      host.sendByte(d, lsb, !rw, g);
      if (live && rw) begin
        rdGot = g;
        ->rdSeen;
      end
      live = live && (len == LEN_STREAM ? a != STREAM_END_ADDR : i < len);
      a = lsb ? a + 8'h01 : a - 8'h01;
      if (i == stall) begin
        host.selectOff();
        host.selectOn();
      end
    end
    host.selectOff();
    checkPin("oe idle", 8'h00, {7'h00, sdioOe});
  endtask : xfer

  // Verdict and end of run
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  // Cut a hang short
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      summarize();
    end
  end

  // Main sequence
  initial begin
    logic [7:0] g;
    logic b;
    rst_n = 1'b0;
    lsbFirst = 1'b0;
    void'($urandom(32'hCF5972B9));
    foreach (mem[i]) mem[i] = 8'($urandom);
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    // Every direction, order and length code; streams hit the stop
    for (int rw = 0; rw < 2; rw++) begin
      for (int lsb = 0; lsb < 2; lsb++) begin
        for (int len = 0; len < 4; len++) begin
          xfer(rw[0], len[1:0], len == 3 ? (lsb ? 8'hFD : 8'h01) :
            8'($urandom), lsb[0], len == 3 ? 5 : len + 1, -1);
        end
      end
    end
    $display("test length codes done");
    xfer(1'b0, LEN_ONE, 8'h5A, 1'b0, 1, -1);
    xfer(1'b1, LEN_ONE, 8'h5A, 1'b0, 1, -1);
    $display("test write then read done");
    xfer(1'b0, LEN_THREE, 8'h80, 1'b0, 3, 0);
    xfer(1'b1, LEN_TWO, 8'h10, 1'b1, 2, 0);
    $display("test stall done");
    // Abort four bits into a byte, then clock with select high
    @(posedge mclk) lsbFirst <= 1'b0;
    host.selectOn();
    host.sendByte(8'h00, 1'b0, 1'b1, g);
    host.sendByte(8'h42, 1'b0, 1'b1, g);
    for (int i = 0; i < 4; i++) host.sendBit(1'b1, 1'b1, b);
    host.selectOff();
    host.sendByte(8'hA5, 1'b0, 1'b1, g);
    xfer(1'b0, LEN_ONE, 8'h42, 1'b0, 1, -1);
    $display("test abort done");
    repeat (8) @(posedge mclk);
    checkReq("leftover", 21'h0,
      21'(expWr.size() + expAddr.size() + expRd.size()));
    summarize();
  end
endmodule : test_serial_config_port_front
`default_nettype wire

// file: verilog/scp_pkg.sv
// Shared constants and carriers of the serial configuration port front end
package scp_pkg;

  // Link framing
  localparam int INSTR_BITS = 16;  // Instruction word length
  localparam int BYTE_BITS = 8;  // Data byte length
  localparam int ADDR_W = 13;  // Start address field width
  localparam int ADDR_LOW_W = 8;  // Address bits that step per byte
  localparam int SYNC_STAGES = 2;  // Flip-flops ahead of any logic

  // Instruction word field positions
  localparam int INSTR_RW_POS = 15;  // Read flag, set for a read
  localparam int INSTR_LEN_HI = 14;  // Transfer length code, top bit
  localparam int INSTR_LEN_LO = 13;  // Transfer length code, low bit
  localparam int INSTR_ADDR_HI = 12;  // Start address field, top bit

  // Counter end values
  localparam logic [3:0] INSTR_LAST_BIT = 4'hF;  // Sixteenth bit index
  localparam logic [3:0] BYTE_LAST_BIT = 4'h7;  // Eighth bit index

  // Transfer length codes
  localparam logic [1:0] LEN_ONE = 2'h0;  // One byte
  localparam logic [1:0] LEN_TWO = 2'h1;  // Two bytes
  localparam logic [1:0] LEN_THREE = 2'h2;  // Three bytes
  localparam logic [1:0] LEN_STREAM = 2'h3;  // Until the byte at STREAM_END_ADDR

  // Streaming stops after the byte at this address
  localparam logic [7:0] STREAM_END_ADDR = 8'hFF;

  // Values after reset
  localparam logic [2:0] SYNC_RESET = 3'h2;  // Clock low, select high
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam logic [15:0] SHIFT_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [12:0] ADDR_RESET = 13'h0000;

  // Phase of a communication cycle
  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_INSTR = 3'b010,
    PH_DATA = 3'b100
  } phase_t;

  // Access toward the configuration register file
  typedef struct packed {
    logic write;  // One-cycle write strobe
    logic read;  // One-cycle read strobe
    logic [12:0] addr;  // Register address
    logic [7:0] data;  // Write data
  } reg_req_t;

  // Drive side of the shared data pin, as two signals
  typedef struct packed {
    logic out;  // Level driven onto the pin
    logic oe;  // High while the block drives the pin
  } pin_drive_t;

endpackage : scp_pkg

// file: verilog/scp_sync.sv
`timescale 1ns/1ns
`default_nettype none

// Two-stage synchroniser for pin levels entering the mclk domain
module scp_sync
  import scp_pkg::*;
#(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);

  // First stage, read only by the second stage
  logic [WIDTH-1:0] meta;

  // Both stages share one reset constant
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= RESET_VAL;
      synced <= RESET_VAL;
    end else begin
      meta <= async;
      synced <= meta;
    end
  end

endmodule : scp_sync

`default_nettype wire

// file: verilog/serial_config_port_front.sv
// What this block does
// - Write bits sampled on serial clock rise
// - Read bits change on serial clock fall
// - Select high: pin released, clock ignored
// - One data pin both receives and drives
// - First rise after select falls: bit zero
// - Sixteen-bit instruction on first sixteen rises
// - Data phase only after full instruction
// - Instruction gives direction, length, start address
// - Every register readable and writable
// - Multi-byte transfers, both bit orders supported
// - Read flag, length code, 13-bit address
// - Length code: one, two, three, stream
// - Address decrements MSB-first, increments LSB-first
// - Mid-byte select rise resets; boundary stalls
`timescale 1ns/1ns
`default_nettype none

module serial_config_port_front
  import scp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic csN,
  input wire logic sdioIn,
  output logic sdioOut,
  output logic sdioOe,
  input wire logic lsbFirst,
  output reg_req_t regReq,
  input wire logic [7:0] regRdData
);

  // Whole state of the port
  typedef struct packed {
    phase_t phase;  // Cycle phase
    logic armed;  // Select seen high since last cycle
    logic sclkPrev;  // Last synced serial clock level
    logic [3:0] cnt;  // Bit index within word or byte
    logic [15:0] shift;  // Incoming bits
    logic isRead;  // Direction of the data phase
    logic stream;  // Streaming length
    logic [1:0] remain;  // Bytes left after the current one
    logic [12:0] addr;  // Address of the current byte
    logic [7:0] outShift;  // Outgoing read byte
    logic loadOut;  // Read data arrives this cycle
    reg_req_t req;  // Registered register access
    pin_drive_t pin;  // Registered pin drive
  } state_t;

  state_t s;  // Current state
  state_t next_s;  // Next state

  logic [2:0] synced;  // Synced clock, select and data
  logic sclkS;  // Synced serial clock
  logic csLow;  // Synced select, active
  logic sdioS;  // Synced data pin
  logic rise;  // Serial clock rising edge
  logic fall;  // Serial clock falling edge
  logic [15:0] shiftIn;  // Shift register with current bit
  logic [7:0] stepAddr;  // Next byte address
  logic lastByte;  // Current byte ends the transfer

  // Pins cross into mclk through two flip-flops
  scp_sync #(
    .WIDTH(3),
    .RESET_VAL(SYNC_RESET)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async({sclk, csN, sdioIn}),
    .synced(synced)
  );

  assign sclkS = synced[2];
  assign csLow = !synced[1];
  assign sdioS = synced[0];

  // Edges only count while select is low
  assign rise = csLow && sclkS && !s.sclkPrev;
  assign fall = csLow && !sclkS && s.sclkPrev;

  // Bit order of the incoming shift follows the current mode
  always_comb begin
    if (lsbFirst) begin
      shiftIn = {sdioS, s.shift[15:1]};
    end else begin
      shiftIn = {s.shift[14:0], sdioS};
    end
  end

  // Address generator and end of transfer
  always_comb begin
    if (lsbFirst) begin
      stepAddr = s.addr[7:0] + 8'h01;
    end else begin
      stepAddr = s.addr[7:0] - 8'h01;
    end
    if (s.stream) begin
      lastByte = (s.addr[7:0] == STREAM_END_ADDR);
    end else begin
      lastByte = (s.remain == 2'h0);
    end
  end

  // Next-state logic
  always_comb begin
    next_s = s;
    next_s.sclkPrev = sclkS;
    next_s.req.write = 1'b0;
    next_s.req.read = 1'b0;
    next_s.loadOut = s.req.read;
    // Read data one cycle after its strobe
    if (s.loadOut) begin
      next_s.outShift = regRdData;
    end
    unique case (s.phase)
      PH_IDLE: begin
        if (!csLow) begin
          next_s.armed = 1'b1;
        end else if (rise && s.armed) begin
          // First rise of a new cycle is bit zero
          next_s.armed = 1'b0;
          next_s.shift = shiftIn;
          next_s.cnt = 4'h1;
          next_s.phase = PH_INSTR;
        end
      end
      PH_INSTR: begin
        if (!csLow) begin
          // Off a byte boundary the port starts over
          if (s.cnt[2:0] != 3'h0) begin
            next_s.phase = PH_IDLE;
            next_s.armed = 1'b1;
          end
        end else if (rise) begin
          next_s.shift = shiftIn;
          next_s.cnt = s.cnt + 4'h1;
          if (s.cnt == INSTR_LAST_BIT) begin
            // Full instruction in hand: decode it
            next_s.phase = PH_DATA;
            next_s.cnt = CNT_RESET;
            next_s.isRead = shiftIn[INSTR_RW_POS];
            next_s.stream = (shiftIn[INSTR_LEN_HI:INSTR_LEN_LO]
              == LEN_STREAM);
            next_s.remain = shiftIn[INSTR_LEN_HI:INSTR_LEN_LO];
            next_s.addr = shiftIn[INSTR_ADDR_HI:0];
            // A read fetches its first byte at once
            next_s.req.read = shiftIn[INSTR_RW_POS];
            next_s.req.addr = shiftIn[INSTR_ADDR_HI:0];
          end
        end
      end
      PH_DATA: begin
        if (!csLow) begin
          if (s.cnt[2:0] != 3'h0) begin
            next_s.phase = PH_IDLE;
            next_s.armed = 1'b1;
          end
        end else begin
          // Read bits leave on falling edges
          if (fall && s.isRead) begin
            if (lsbFirst) begin
              next_s.pin.out = s.outShift[0];
              next_s.outShift = {1'b0, s.outShift[7:1]};
            end else begin
              next_s.pin.out = s.outShift[7];
              next_s.outShift = {s.outShift[6:0], 1'b0};
            end
          end
          if (rise) begin
            next_s.shift = shiftIn;
            next_s.cnt = s.cnt + 4'h1;
            if (s.cnt == BYTE_LAST_BIT) begin
              // Byte complete: store it or fetch the next one
              next_s.cnt = CNT_RESET;
              next_s.remain = s.remain - 2'h1;
              next_s.addr = {s.addr[12:8], stepAddr};
              if (!s.isRead) begin
                next_s.req.write = 1'b1;
                next_s.req.addr = s.addr;
                next_s.req.data = shiftIn[7:0];
                if (lsbFirst) begin
                  next_s.req.data = shiftIn[15:8];
                end
              end else if (!lastByte) begin
                next_s.req.read = 1'b1;
                next_s.req.addr = {s.addr[12:8], stepAddr};
              end
              if (lastByte) begin
                next_s.phase = PH_IDLE;
              end
            end
          end
        end
      end
      default: begin
        next_s.phase = PH_IDLE;
      end
    endcase
    // Pin driven only in the read data phase with select low
    next_s.pin.oe = (next_s.phase == PH_DATA) && next_s.isRead
      && csLow;
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s.phase <= PH_IDLE;
      s.armed <= 1'b0;
      s.sclkPrev <= 1'b0;
      s.cnt <= CNT_RESET;
      s.shift <= SHIFT_RESET;
      s.isRead <= 1'b0;
      s.stream <= 1'b0;
      s.remain <= 2'h0;
      s.addr <= ADDR_RESET;
      s.outShift <= BYTE_RESET;
      s.loadOut <= 1'b0;
      s.req <= '0;
      s.pin <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from flip-flops
  assign sdioOut = s.pin.out;
  assign sdioOe = s.pin.oe;
  assign regReq = s.req;

  // Checks
  property p_oeOnlyRead;
    @(posedge mclk) disable iff (!rst_n)
      sdioOe |-> (s.phase == PH_DATA) && s.isRead;
  endproperty
  a_oeOnlyRead: assert property (p_oeOnlyRead)
    else $error("data pin driven outside read data phase");

  property p_csHighReleases;
    @(posedge mclk) disable iff (!rst_n)
      !csLow |=> !sdioOe;
  endproperty
  a_csHighReleases: assert property (p_csHighReleases)
    else $error("data pin driven while select high");

  property p_outOnFall;
    @(posedge mclk) disable iff (!rst_n)
      $changed(sdioOut) |-> $past(fall);
  endproperty
  a_outOnFall: assert property (p_outOnFall)
    else $error("read bit changed without a falling edge");

  property p_startBitZero;
    @(posedge mclk) disable iff (!rst_n)
      (s.phase == PH_IDLE) && s.armed && rise |=>
        (s.phase == PH_INSTR) && (s.cnt == 4'h1);
  endproperty
  a_startBitZero: assert property (p_startBitZero)
    else $error("cycle did not start on first rise");

  property p_instrDone;
    @(posedge mclk) disable iff (!rst_n)
      (s.phase == PH_INSTR) && rise && (s.cnt == INSTR_LAST_BIT) |=>
        (s.phase == PH_DATA) && (s.cnt == CNT_RESET);
  endproperty
  a_instrDone: assert property (p_instrDone)
    else $error("data phase not entered after sixteen bits");

  property p_dataAfterInstr;
    @(posedge mclk) disable iff (!rst_n)
      $rose(s.phase == PH_DATA) |-> $past(s.phase) == PH_INSTR;
  endproperty
  a_dataAfterInstr: assert property (p_dataAfterInstr)
    else $error("data phase entered early");

  property p_readFetch;
    @(posedge mclk) disable iff (!rst_n)
      $rose(s.phase == PH_DATA) && s.isRead |-> s.req.read
        ##1 s.loadOut ##1 (s.outShift == $past(regRdData));
  endproperty
  a_readFetch: assert property (p_readFetch)
    else $error("read start did not fetch first byte");

  property p_writeStrobe;
    @(posedge mclk) disable iff (!rst_n)
      (s.phase == PH_DATA) && !s.isRead && rise
        && (s.cnt == BYTE_LAST_BIT) |=> s.req.write && (s.req.addr
        == $past(s.addr));
  endproperty
  a_writeStrobe: assert property (p_writeStrobe)
    else $error("write byte not stored after eighth bit");

  property p_addrStep;
    @(posedge mclk) disable iff (!rst_n)
      (s.phase == PH_DATA) && rise && (s.cnt == BYTE_LAST_BIT)
        && !lsbFirst |=> s.addr[7:0] == $past(s.addr[7:0]) - 8'h01;
  endproperty
  a_addrStep: assert property (p_addrStep)
    else $error("address did not decrement");

  property p_midByteReset;
    @(posedge mclk) disable iff (!rst_n)
      !csLow && (s.phase != PH_IDLE) && (s.cnt[2:0] != 3'h0) |=>
        (s.phase == PH_IDLE);
  endproperty
  a_midByteReset: assert property (p_midByteReset)
    else $error("mid-byte select rise did not reset");

  property p_oneByteEnds;
    @(posedge mclk) disable iff (!rst_n)
      (s.phase == PH_DATA) && !s.stream && (s.remain == LEN_ONE)
        && rise && (s.cnt == BYTE_LAST_BIT) |=> s.phase == PH_IDLE;
  endproperty
  a_oneByteEnds: assert property (p_oneByteEnds)
    else $error("transfer ran past its last byte");

  c_write: cover property (@(posedge mclk) disable iff (!rst_n)
    s.req.write);
  c_readDrive: cover property (@(posedge mclk) disable iff (!rst_n)
    sdioOe ##1 !sdioOe);
  c_stall: cover property (@(posedge mclk) disable iff (!rst_n)
    (s.phase == PH_DATA) && !csLow && (s.cnt == CNT_RESET));
  c_stream: cover property (@(posedge mclk) disable iff (!rst_n)
    s.stream && $fell(s.phase == PH_DATA));

endmodule : serial_config_port_front

`default_nettype wire
